//--- hw/apag_guard.sv
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Function
// - Precharge runs only when precharge time is non-zero at start.
// - Go bit, special trigger or restart each start the sequence.
// - Precharge ties hold capacitor to supply chosen by precharge_polarity.
// - Precharge drives channel pin high or low per precharge_polarity.
// - Pin override ignores the pin_direction setting.
// - Precharge lasts the precharge-time register count.
// - Acquisition lasts acquisition_time; starts after precharge or at start.
// - Acquisition releases pin drivers and joins channel to hold capacitor.
// - Precharge on and acquisition zero gives 8191 cycles.
// - Precharge off and acquisition zero skips timed acquisition.
// - Two guard outputs, polarity from guard and invert-enable bits.
// - First precharge start sets both guards to guard_polarity.
// - Acquisition start inverts guard A, keeps guard B.
// - Second sample with invert: both opposite, then guard A toggles.
// - Format clear: upper byte holds result bits 11:4.
// - Format clear: lower register bits 7-4 result 3:0, 3-0 zero.
module apag_guard
  import apag_pkg::*;
(
  input  wire logic                aclk,          // 100 MHz clock
  input  wire logic                aresetn,       // Sync reset, low
  input  wire logic                clk_en,        // Freezes state when low
  input  wire logic                trig_async,    // Special event trigger pin
  input  wire logic                restart_req,   // Restart from compute logic
  input  wire logic                conv_done,     // Converter finished
  input  wire logic [11:0]         conv_data,     // Converter result
  output logic                     conv_start,    // Start conversion stage
  output apag_pkg::apag_pin_type   pin_ctl,       // Pin and hold switches
  output logic                     guard_out_a,   // Guard ring A
  output logic                     guard_out_b,   // Guard ring B
  input  wire logic [7:0]          s_axi_awaddr,  // Write address
  input  wire logic                s_axi_awvalid, // Write address valid
  output logic                     s_axi_awready, // Write address ready
  input  wire logic [31:0]         s_axi_wdata,   // Write data
  input  wire logic [3:0]          s_axi_wstrb,   // Write strobes
  input  wire logic                s_axi_wvalid,  // Write data valid
  output logic                     s_axi_wready,  // Write data ready
  output logic [1:0]               s_axi_bresp,   // Write response
  output logic                     s_axi_bvalid,  // Write response valid
  input  wire logic                s_axi_bready,  // Response ready
  input  wire logic [7:0]          s_axi_araddr,  // Read address
  input  wire logic                s_axi_arvalid, // Read address valid
  output logic                     s_axi_arready, // Read address ready
  output logic [31:0]              s_axi_rdata,   // Read data
  output logic [1:0]               s_axi_rresp,   // Read response
  output logic                     s_axi_rvalid,  // Read data valid
  input  wire logic                s_axi_rready   // Read ready
);
  import apag_pkg::*;

  apag_state_type   st_r, st_nxt;
  logic [12:0]      cnt_r, cnt_nxt;
  logic             second_r, second_nxt;
  logic             ga_r, ga_nxt, gb_r, gb_nxt;
  apag_pin_type     pin_r, pin_nxt;
  logic             cs_r, cs_nxt;
  logic [5:0]       ctrl_r, ctrl_nxt, ctrl_now;
  logic [12:0]      pre_r, pre_nxt, acq_r, acq_nxt;
  logic [11:0]      res_r, res_nxt;
  logic [2:0]       trg_r;
  logic             trg_old_r;
  logic             aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]       awa_r, awa_nxt;
  logic [31:0]      wd_r, wd_nxt;
  logic             bv_r, bv_nxt, rv_r, rv_nxt, ws_r, ws_nxt;
  logic [1:0]       br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic             trig_ev, start_ev, wr_go, wr_fire;

  // Trigger pin, three stages; edge counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_r     <= 3'h0;
      trg_old_r <= 1'b0;
    end else if (clk_en) begin
      trg_r <= {trg_r[1:0], trig_async};
      if (trg_r[2] == trg_r[1]) trg_old_r <= trg_r[2];
    end
  end
  assign trig_ev  = (trg_r[2] == trg_r[1]) && trg_r[2] && !trg_old_r;
  assign wr_fire  = aw_got_r && w_got_r && !bv_r;
  assign wr_go    = wr_fire && awa_r == OFS_CTRL && ws_r && wd_r[CTRL_GO];
  assign start_ev = wr_go || trig_ev || restart_req;
  assign ctrl_now = wr_go ? wd_r[5:0] : ctrl_r; // Fields ride with go

  // Sequencer next state
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    second_nxt = second_r;
    ga_nxt     = ga_r;
    gb_nxt     = gb_r;
    pin_nxt    = pin_r;
    cs_nxt     = 1'b0;
    case (st_r)
      ST_IDLE: begin
        pin_nxt = PIN_IDLE;
        if (start_ev) begin
          second_nxt = 1'b0;
          ga_nxt = ctrl_now[CTRL_GPOL];
          gb_nxt = ctrl_now[CTRL_GPOL];
          if (pre_r != CNT_ZERO) begin
            st_nxt  = ST_PRE;
            cnt_nxt = pre_r;
            // Drives even when pin is an input
            pin_nxt = '{pin_out: ctrl_now[CTRL_PPOL], pin_oe_n: 1'b0,
                        hold_to_rail: 1'b1,
                        hold_rail_hi: ctrl_now[CTRL_PPOL],
                        hold_to_chan: 1'b0};
          end else if (acq_r != CNT_ZERO) begin
            st_nxt  = ST_ACQ;
            cnt_nxt = acq_r;
            ga_nxt  = !ctrl_now[CTRL_GPOL];
            pin_nxt.hold_to_chan = 1'b1;
          end else begin
            st_nxt = ST_CONV;
            cs_nxt = 1'b1;
            pin_nxt.hold_to_chan = 1'b1;
          end
        end
      end
      ST_PRE: begin
        if (cnt_r == 13'h0001) begin
          st_nxt  = ST_ACQ;
          cnt_nxt = (acq_r == CNT_ZERO) ? ACQ_MAX : acq_r;
          ga_nxt  = !ga_r;
          pin_nxt = '{pin_out: 1'b0, pin_oe_n: 1'b1, hold_to_rail: 1'b0,
                      hold_rail_hi: 1'b0, hold_to_chan: 1'b1};
        end else cnt_nxt = cnt_r - 13'h0001;
      end
      ST_ACQ: begin
        if (cnt_r == 13'h0001) begin
          st_nxt = ST_CONV;
          cs_nxt = 1'b1;
          pin_nxt.hold_to_chan = 1'b0;
        end else cnt_nxt = cnt_r - 13'h0001;
      end
      ST_CONV: begin
        if (conv_done) st_nxt = ST_DONE;
      end
      ST_DONE: begin
        if (ctrl_r[CTRL_DOUBLE] && !second_r && pre_r != CNT_ZERO) begin
          second_nxt = 1'b1;
          st_nxt     = ST_PRE;
          cnt_nxt    = pre_r;
          if (ctrl_r[CTRL_IPEN]) begin
            ga_nxt = !ctrl_r[CTRL_GPOL];
            gb_nxt = !ctrl_r[CTRL_GPOL];
          end
          pin_nxt = '{pin_out: ctrl_r[CTRL_PPOL], pin_oe_n: 1'b0,
                      hold_to_rail: 1'b1,
                      hold_rail_hi: ctrl_r[CTRL_PPOL],
                      hold_to_chan: 1'b0};
        end else st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r     <= ST_IDLE;
      cnt_r    <= TIME_RST;
      second_r <= 1'b0;
      ga_r     <= 1'b0;
      gb_r     <= 1'b0;
      pin_r    <= PIN_IDLE;
      cs_r     <= 1'b0;
    end else if (clk_en) begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      second_r <= second_nxt;
      ga_r     <= ga_nxt;
      gb_r     <= gb_nxt;
      pin_r    <= pin_nxt;
      cs_r     <= cs_nxt;
    end
  end

  // Register file and AXI4-Lite slave; one write, one read at a time
  always_comb begin
    ctrl_nxt   = ctrl_r;
    pre_nxt    = pre_r;
    acq_nxt    = acq_r;
    res_nxt    = res_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awa_nxt    = awa_r;
    wd_nxt     = wd_r;
    bv_nxt     = bv_r;
    br_nxt     = br_r;
    rv_nxt     = rv_r;
    rr_nxt     = rr_r;
    rd_nxt     = rd_r;
    ws_nxt     = ws_r;
    if (s_axi_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awa_nxt    = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      wd_nxt    = s_axi_wdata;
      ws_nxt    = s_axi_wstrb[0] || s_axi_wstrb[1]; // Strobes ride with data
    end
    // Go bit is self-clearing; busy shows in the status register
    if (st_r == ST_DONE && st_nxt == ST_IDLE) ctrl_nxt[CTRL_GO] = 1'b0;
    if (st_r == ST_CONV && conv_done) res_nxt = conv_data;
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bv_nxt     = 1'b1;
      br_nxt     = AXI_OKAY;
      if (ws_r) begin
        case (awa_r)
          OFS_CTRL: begin
            ctrl_nxt = wd_r[5:0];
            ctrl_nxt[CTRL_GO] = wd_r[CTRL_GO] || (st_nxt != ST_IDLE);
          end
          OFS_PRE: pre_nxt = wd_r[12:0];
          OFS_ACQ: acq_nxt = wd_r[12:0];
          OFS_RES_HI: res_nxt[11:4] = wd_r[7:0];
          OFS_RES_LO: res_nxt[3:0]  = wd_r[7:4];
          OFS_STATUS, OFS_CONV_RES: ;
          default: br_nxt = AXI_SLVERR;
        endcase
      end
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (s_axi_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rr_nxt = AXI_OKAY;
      rd_nxt = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CTRL: rd_nxt[5:0]  = ctrl_r;
        OFS_PRE:  rd_nxt[12:0] = pre_r;
        OFS_ACQ:  rd_nxt[12:0] = acq_r;
        OFS_RES_HI: rd_nxt[7:0] = res_r[11:4];
        OFS_RES_LO: rd_nxt[7:0] = {res_r[3:0], 4'h0};
        OFS_STATUS: rd_nxt[7:0] = {1'b0, gb_r, ga_r, st_r};
        OFS_CONV_RES: rd_nxt[11:0] = res_r;
        default: rr_nxt = AXI_SLVERR;
      endcase
    end else if (rv_r && s_axi_rready) rv_nxt = 1'b0;
  end

  // Register file flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      pre_r  <= TIME_RST;
      acq_r  <= TIME_RST;
      res_r  <= RES_RST;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r  <= 8'h00;
      wd_r   <= 32'h0000_0000;
      bv_r   <= 1'b0;
      br_r   <= AXI_OKAY;
      rv_r   <= 1'b0;
      rr_r   <= AXI_OKAY;
      rd_r   <= 32'h0000_0000;
      ws_r   <= 1'b0;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      pre_r  <= pre_nxt;
      acq_r  <= acq_nxt;
      res_r  <= res_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awa_r  <= awa_nxt;
      wd_r   <= wd_nxt;
      bv_r   <= bv_nxt;
      br_r   <= br_nxt;
      rv_r   <= rv_nxt;
      rr_r   <= rr_nxt;
      rd_r   <= rd_nxt;
      ws_r   <= ws_nxt;
    end
  end

  // Outputs straight from flops
  assign conv_start    = cs_r;
  assign pin_ctl       = pin_r;
  assign guard_out_a   = ga_r;
  assign guard_out_b   = gb_r;
  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready  = !w_got_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rresp   = rr_r;
  assign s_axi_rdata   = rd_r;

  // Checks
  a_pre_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_PRE |-> !pin_r.pin_oe_n && pin_r.hold_to_rail)
    else $error("pin not driven in precharge");
  a_pre_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_r == ST_IDLE && start_ev && pre_r != CNT_ZERO |=>
    pin_r.pin_out == $past(ctrl_now[CTRL_PPOL]))
    else $error("precharge polarity wrong");
  a_pre_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_r == ST_IDLE && start_ev && pre_r == CNT_ZERO |=>
    st_r != ST_PRE)
    else $error("precharge not skipped");
  a_acq_max: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_r == ST_PRE && st_nxt == ST_ACQ && acq_r == CNT_ZERO
    |=> cnt_r == 13'h1FFF)
    else $error("max acquisition not loaded");
  a_acq_release: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_ACQ |-> pin_r.pin_oe_n && pin_r.hold_to_chan)
    else $error("acquisition pin state wrong");
  a_guard_a_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_r == ST_PRE && st_nxt == ST_ACQ |=>
    ga_r != $past(ga_r) && gb_r == $past(gb_r))
    else $error("guard A did not toggle");
  a_guard_first: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_r == ST_IDLE && start_ev && pre_r != CNT_ZERO |=>
    gb_r == $past(ctrl_now[CTRL_GPOL]) && ga_r == gb_r)
    else $error("guard start level wrong");
  a_zero_acq: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_r == ST_IDLE && start_ev && pre_r == CNT_ZERO &&
    acq_r == CNT_ZERO |=> st_r == ST_CONV && cs_r)
    else $error("zero acquisition not bypassed");
  a_res_lo: assert property (@(posedge aclk) disable iff (!aresetn)
    rv_r && $past(s_axi_araddr) == OFS_RES_LO && $rose(rv_r) |->
    s_axi_rdata[3:0] == 4'h0)
    else $error("low nibble bits not zero");
  c_pre_path: cover property (@(posedge aclk) st_r == ST_PRE ##1
    st_r == ST_ACQ);
  c_second: cover property (@(posedge aclk) second_r && st_r == ST_PRE);
  c_direct: cover property (@(posedge aclk) st_r == ST_IDLE ##1
    st_r == ST_CONV);
endmodule : apag_guard

//--- hw/apag_pkg.sv
package apag_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PRE      = 8'h04;
  localparam logic [7:0] OFS_ACQ      = 8'h08;
  localparam logic [7:0] OFS_RES_HI   = 8'h0C;
  localparam logic [7:0] OFS_RES_LO   = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_CONV_RES = 8'h18;
  // Control field positions
  localparam int CTRL_GO       = 0;
  localparam int CTRL_PPOL     = 1;
  localparam int CTRL_GPOL     = 2;
  localparam int CTRL_IPEN     = 3;
  localparam int CTRL_DOUBLE   = 4;
  localparam int CTRL_FMT      = 5;
  // Widths and counts
  localparam int CNT_W = 13;
  localparam logic [12:0] ACQ_MAX  = 13'h1FFF;
  localparam logic [12:0] CNT_ZERO = 13'h0000;
  // Reset values and AXI response codes
  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam logic [12:0] TIME_RST = 13'h0000;
  localparam logic [11:0] RES_RST  = 12'h000;
  localparam logic [1:0]  AXI_OKAY   = 2'b00;
  localparam logic [1:0]  AXI_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PRE  = 5'b00010,
    ST_ACQ  = 5'b00100,
    ST_CONV = 5'b01000,
    ST_DONE = 5'b10000
  } apag_state_type;

  // Pin override bundle
  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
    logic hold_to_rail;
    logic hold_rail_hi;
    logic hold_to_chan;
  } apag_pin_type;

  // Pin state while idle and after reset: released, hold switches open
  localparam apag_pin_type PIN_IDLE = '{pin_out: 1'b0, pin_oe_n: 1'b1,
    hold_to_rail: 1'b0, hold_rail_hi: 1'b0, hold_to_chan: 1'b0};
endpackage : apag_pkg

//--- verif/apag_guard_bench.sv
`timescale 1ns/1ns
module apag_guard_bench;
  import apag_pkg::*;
  typedef struct {
    logic [12:0] pre, acq; logic pp, gp; logic [11:0] lv; int m;
  } apag_row_type;
  logic aclk = 0, aresetn = 0, clk_en = 1, trig_async = 0, restart_req = 0;
  logic conv_done, conv_start, guard_out_a, guard_out_b;
  logic [11:0] conv_data, level = 12'h000;
  logic [7:0]  lat = 8'h00;
  apag_pin_type pin_ctl;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d, ctrl, ea;
  logic [6:0]  pre_q[$], acq_q[$], msk;
  logic        tr_d = 0, tc_d = 0, run = 0, run_d = 0, done_r = 0;
  int          pre_n, acq_n, failures = 0, cmp_count = 0, cyc = 0;
  apag_row_type rw;
  apag_row_type rows[5] = '{
    '{13'h0003, 13'h0004, 0, 0, 12'hABC, 0},
    '{13'h0001, 13'h0001, 1, 1, 12'h123, 1},
    '{13'h0000, 13'h0005, 1, 0, 12'hFFF, 2},
    '{13'h0000, 13'h0000, 0, 1, 12'h801, 0},
    '{13'h0002, 13'h0000, 1, 0, 12'h00F, 0}};
  wire [6:0] snap = {guard_out_a, guard_out_b, pin_ctl};

  apag_guard dut_u (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clk_en        (clk_en),
    .trig_async    (trig_async),
    .restart_req   (restart_req),
    .conv_done     (conv_done),
    .conv_data     (conv_data),
    .conv_start    (conv_start),
    .pin_ctl       (pin_ctl),
    .guard_out_a   (guard_out_a),
    .guard_out_b   (guard_out_b),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );
  apag_sensor sensor_u (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .conv_start (conv_start),
    .level      (level),
    .lat        (lat),
    .conv_done  (conv_done),
    .conv_data  (conv_data)
  );

  always #5 aclk = ~aclk;
  // Stage lengths and a snapshot at each precharge and acquisition entry
  always @(posedge aclk) begin
    tr_d <= pin_ctl.hold_to_rail;
    tc_d <= pin_ctl.hold_to_chan;
    run_d <= run;
    if (pin_ctl.hold_to_rail) pre_n++;
    if (pin_ctl.hold_to_rail && !tr_d) pre_q.push_back(snap);
    if (pin_ctl.hold_to_chan && !tc_d) acq_q.push_back(snap);
    if (pin_ctl.hold_to_chan && !conv_start && !done_r) acq_n++;
    if (run != run_d) done_r <= 0;
    else if (conv_start) done_r <= 1;
  end
  // Hang guard, sized well above the longest acquisition
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Entered just after a rising edge; channels released as taken
  task wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rs = s_axi_bresp;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd

  // Start by go bit, trigger pin or restart, then wait for idle
  task start(input int m);
    run <= ~run;
    @(posedge aclk);
    if (m == 0) wr(OFS_CTRL, ctrl | 32'h1, r);
    else if (m == 1) begin
      trig_async <= 1;
      repeat (3) @(posedge aclk);
      trig_async <= 0;
    end else begin
      restart_req <= 1;
      @(posedge aclk);
      restart_req <= 0;
    end
    while (!done_r) @(posedge aclk);
    d = 32'h0;
    while (d[4:0] !== 5'h01) rd(OFS_STATUS, d, r);
  endtask : start

  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rw = rows[i];
      level <= rw.lv;
      lat <= 8'(i * 3);
      ctrl = {29'h0, rw.gp, rw.pp, 1'b0};
      wr(OFS_PRE, {19'h0, rw.pre}, r);
      wr(OFS_ACQ, {19'h0, rw.acq}, r);
      wr(OFS_CTRL, ctrl, r);
      rd(OFS_PRE, d, r);
      chk("pre reg", {19'h0, rw.pre}, d);
      pre_q.delete();
      acq_q.delete();
      pre_n = 0;
      acq_n = 0;
      start(rw.m);
      ea = rw.acq != 0 ? rw.acq : (rw.pre != 0 ? ACQ_MAX : 13'h0);
      chk("pre length", rw.pre, pre_n);
      chk("acq length", ea, acq_n);
      if (rw.pre != 0)
        chk("pre pins", {rw.gp, rw.gp, rw.pp, 2'b01, rw.pp, 1'b0},
            pre_q[0]);
      msk = rw.pre != 0 ? 7'h6D : 7'h0D;
      if (ea != 0)
        chk("acq pins", {~rw.gp, rw.gp, 5'h09} & msk,
            acq_q[0] & msk);
      rd(OFS_CTRL, d, r);
      chk("go cleared", ctrl, d);
      rd(OFS_RES_HI, d, r);
      chk("result upper", rw.lv[11:4], d);
      rd(OFS_RES_LO, d, r);
      chk("result lower", {rw.lv[3:0], 4'h0}, d);
      $display("row %0d done", i);
    end
    // Double sample with inverted second pass
    wr(OFS_PRE, 32'h3, r);
    wr(OFS_ACQ, 32'h2, r);
    ctrl = 32'h1C;
    pre_q.delete();
    acq_q.delete();
    start(0);
    chk("double guards", 8'hD2, {pre_q[0][6:5], acq_q[0][6:5],
        pre_q[1][6:5], acq_q[1][6:5]});
    $display("double sample done");
    wr(8'h20, 32'h0, r);
    chk("write unmapped", AXI_SLVERR, r);
    rd(8'h1C, d, r);
    chk("read unmapped", AXI_SLVERR, r);
    $display("unmapped done");
    // Reset in mid precharge
    wr(OFS_PRE, 32'h100, r);
    wr(OFS_CTRL, 32'h3, r);
    repeat (5) @(posedge aclk);
    // Frozen clock enable must hold precharge past its own count
    ea = snap;
    clk_en <= 0;
    repeat (300) @(posedge aclk);
    chk("freeze pins", ea, snap);
    clk_en <= 1;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    chk("reset pins", 7'h08, snap);
    chk("reset ready", 1'b1, s_axi_awready);
    aresetn <= 1;
    rd(OFS_PRE, d, r);
    chk("reset pre reg", 32'h0, d);
    rd(OFS_STATUS, d, r);
    chk("reset status", 32'h1, d);
    $display("reset done");
    close_out();
  end
endmodule : apag_guard_bench

//--- verif/apag_sensor.sv
`timescale 1ns/1ns
// Sensor and converter stand-in: returns the sensed level after lat cycles
module apag_sensor (
  input  wire logic        aclk,       // 100 MHz clock
  input  wire logic        aresetn,    // Sync reset, low
  input  wire logic        conv_start, // Conversion begins
  input  wire logic [11:0] level,      // Sensed charge level
  input  wire logic [7:0]  lat,        // Answer delay, prompt or slow
  output logic             conv_done,  // Result strobe
  output logic [11:0]      conv_data   // Result bus
);
  logic [8:0] cnt_r;
  // Countdown to the result strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_r <= 9'h000;
    else if (conv_start) cnt_r <= {1'b0, lat} + 9'h001;
    else if (cnt_r != 9'h000) cnt_r <= cnt_r - 9'h001;
  end
  assign conv_done = (cnt_r == 9'h001);
  // Data off the strobe always differs from level, alternating while counting, so a stale capture cannot pass
  assign conv_data = conv_done ? level :
                     (cnt_r[0] ? ~level : level ^ 12'h5A5);
endmodule : apag_sensor
